// ### design/regbank_defines.vh
// Purpose: Offsets, reset values and field positions of the register bank
// Assumes: 6-bit address, 8-bit data
// Notes: Included by the bank's top design file and by the bench files
`ifndef REGBANK_DEFINES_VH
`define REGBANK_DEFINES_VH

`define ADDR_W 6
`define DATA_W 8

`define OFF_CHANNEL_ON_CONTROL 6'h00
`define OFF_CONFIG_A 6'h01
`define OFF_CONFIG_B 6'h02
`define OFF_SWITCHING_DIVIDER 6'h03
`define OFF_SLOPE_COMP_CFG 6'h04
`define OFF_SPREAD_SPECTRUM_CFG 6'h05
`define OFF_RAMP_TIME_CFG 6'h06
`define OFF_CH1_CURRENT_LEVEL 6'h07
`define OFF_CH2_CURRENT_LEVEL 6'h08
`define OFF_DIMMING_CLOCK_DIVIDER 6'h09
`define OFF_CH1_DIM_DUTY_LOW 6'h0a
`define OFF_CH1_DIM_DUTY_HIGH 6'h0b
`define OFF_CH2_DIM_DUTY_LOW 6'h0c
`define OFF_CH2_DIM_DUTY_HIGH 6'h0d
`define OFF_CURRENT_LIMIT_CFG 6'h0e
`define OFF_CURRENT_FAULT_TIMER 6'h0f
`define OFF_MODE_FAULT_TIMER 6'h10
`define OFF_FAULT_STATUS_A 6'h11
`define OFF_FAULT_STATUS_B 6'h12
`define OFF_FAULT_ENABLE_A 6'h13
`define OFF_FAULT_ENABLE_B 6'h14
`define OFF_FAULT_LATCH_SELECT 6'h15
`define OFF_OUTPUT_HIGH_LIMIT_SELECT 6'h16
`define OFF_LIMP_HOME_CONFIG 6'h17
`define OFF_LIMP_HOME_CH1_CURRENT 6'h18
`define OFF_LIMP_HOME_CH2_CURRENT 6'h19
`define OFF_LAST 6'h19

`define RST_CHANNEL_ON_CONTROL 8'h3c
`define RST_CONFIG_A 8'h00
`define RST_CONFIG_B 8'h00
`define RST_SWITCHING_DIVIDER 8'h00
`define RST_SLOPE_COMP_CFG 8'h55
`define RST_SPREAD_SPECTRUM_CFG 8'h05
`define RST_RAMP_TIME_CFG 8'h77
`define RST_CH1_CURRENT_LEVEL 8'h00
`define RST_CH2_CURRENT_LEVEL 8'h00
`define RST_DIMMING_CLOCK_DIVIDER 8'h01
`define RST_CH1_DIM_DUTY_LOW 8'h00
`define RST_CH1_DIM_DUTY_HIGH 8'h00
`define RST_CH2_DIM_DUTY_LOW 8'h00
`define RST_CH2_DIM_DUTY_HIGH 8'h00
`define RST_CURRENT_LIMIT_CFG 8'h0f
`define RST_CURRENT_FAULT_TIMER 8'h0a
`define RST_MODE_FAULT_TIMER 8'h99
`define RST_FAULT_STATUS_A 8'h20
`define RST_FAULT_ENABLE_A 8'h3c
`define RST_FAULT_ENABLE_B 8'h0f
`define RST_FAULT_LATCH_SELECT 8'h00
`define RST_OUTPUT_HIGH_LIMIT_SELECT 8'h22
`define RST_LIMP_HOME_CONFIG 8'h3c
`define RST_LIMP_HOME_CH1_CURRENT 8'h00
`define RST_LIMP_HOME_CH2_CURRENT 8'h00

// Writable-bit masks; cleared bits are reserved and read zero
`define MASK_CONFIG_B 8'hc9
`define MASK_SWITCHING_DIVIDER 8'h0f
`define MASK_SLOPE_COMP_CFG 8'h77
`define MASK_SPREAD_SPECTRUM_CFG 8'h3f
`define MASK_DIMMING_CLOCK_DIVIDER 8'h07
`define MASK_DIM_DUTY_HIGH 8'h03
`define MASK_CURRENT_FAULT_TIMER 8'h0f
`define MASK_FAULT_ENABLE_B 8'hbf
`define MASK_OUTPUT_HIGH_LIMIT_SELECT 8'h77
`define MASK_FULL 8'hff

// Field positions
`define BIT_FAULT_PIN_CLEAR 7
`define BIT_CH2_ON 1
`define BIT_CH1_ON 0
`define BIT_POWER_CYCLED 5
`define BIT_LIMP_HOME 4
`define MASK_FAULT_STATUS_A 8'hbf

`endif

// ### design/rw_reg8.v
// Purpose: One 8-bit read/write register with reset value and bit mask
// Assumes: Synchronous active-high reset
// Notes: Masked-off bits hold zero and read zero
`timescale 1ns/1ps
module rw_reg8 #(
  parameter [7:0] RESET_VALUE = 8'h00,
  parameter [7:0] WR_MASK = 8'hff
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire wr_in,
  input wire [7:0] wdata_in,
  output wire [7:0] value_out
);

  reg [7:0] value_q;

  always @(posedge ref_clk_in)
  begin
    if (rst_in)
      value_q <= RESET_VALUE & WR_MASK;
    else if (wr_in)
      value_q <= wdata_in & WR_MASK;
  end

  assign value_out = value_q;

endmodule

// ### design/fault_status_reg.v
// Purpose: Sticky fault status byte, cleared by a clean read
// Assumes: Fault events are one-cycle or level pulses, synchronous
// Notes: A set in the clearing cycle wins over the clear
`timescale 1ns/1ps
module fault_status_reg #(
  parameter [7:0] RESET_VALUE = 8'h00,
  parameter [7:0] MASK = 8'hff
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire [7:0] set_in,
  input wire clear_in,
  output wire [7:0] value_out
);

  reg [7:0] value_q;
  reg [7:0] value_d;

  always @*
  begin
    value_d = value_q;
    if (clear_in)
      value_d = 8'h00;
    value_d = (value_d | set_in) & MASK;
  end

  always @(posedge ref_clk_in)
  begin
    if (rst_in)
      value_q <= RESET_VALUE & MASK;
    else
      value_q <= value_d;
  end

  assign value_out = value_q;

endmodule

// ### design/led_controller_register_bank.v
// Purpose: Register array of a dual-channel LED/voltage controller
// Assumes: Decoded 16-bit frames arrive as command strobes from the
//   serial frame engine; all inputs synchronous to ref_clk_in
// Notes: Read data is registered one cycle after the read strobe
//
// What this block does
// - Registers are 8 bits wide, 6-bit address, 0x00 to 0x3F.
// - Reset loads every register with its default before any access.
// - Reads of undefined addresses return zero.
// - Registers read and write unless described otherwise.
// - A write flagged with a serial error leaves the register unchanged.
// - An error-free read of fault status clears it; first one of status A clears power-cycled.
// - Fault-pin clear bit is write-only and reads zero.
// - Channel-on writes of one blocked while power-cycled is high.
`timescale 1ns/1ps
`include "regbank_defines.vh"
module led_controller_register_bank (
  input wire ref_clk_in,
  input wire rst_in,
  input wire cmd_valid_in,
  input wire cmd_write_in,
  input wire cmd_error_in,
  input wire [5:0] cmd_addr_in,
  input wire [7:0] cmd_wdata_in,
  input wire [7:0] fault_a_set_in,
  input wire [7:0] fault_b_set_in,
  input wire limp_home_pin_in,
  input wire ch1_latched_fault_in,
  input wire ch2_latched_fault_in,
  output reg [7:0] rdata_out,
  output reg rdata_valid_out,
  output reg fault_pin_clear_out,
  output wire [7:0] channel_on_control_out,
  output wire [7:0] config_a_out,
  output wire [7:0] config_b_out,
  output wire [7:0] switching_divider_out,
  output wire [7:0] slope_comp_cfg_out,
  output wire [7:0] spread_spectrum_cfg_out,
  output wire [7:0] ramp_time_cfg_out,
  output wire [7:0] ch1_current_level_out,
  output wire [7:0] ch2_current_level_out,
  output wire [7:0] dimming_clock_divider_out,
  output wire [9:0] ch1_dim_duty_out,
  output wire [9:0] ch2_dim_duty_out,
  output wire [7:0] current_limit_cfg_out,
  output wire [7:0] current_fault_timer_out,
  output wire [7:0] mode_fault_timer_out,
  output wire [7:0] fault_status_a_out,
  output wire [7:0] fault_status_b_out,
  output wire [7:0] fault_enable_a_out,
  output wire [7:0] fault_enable_b_out,
  output wire [7:0] fault_latch_select_out,
  output wire [7:0] output_high_limit_select_out,
  output wire [7:0] limp_home_config_out,
  output wire [7:0] limp_home_ch1_current_out,
  output wire [7:0] limp_home_ch2_current_out
);

  ////////////////////////////////////////////////////////////////////////
  // Command qualification

  wire wr_ok;
  wire rd_ok;
  wire [7:0] wdata;

  assign wr_ok = cmd_valid_in & cmd_write_in & ~cmd_error_in;
  assign rd_ok = cmd_valid_in & ~cmd_write_in;
  assign wdata = cmd_wdata_in;

  // One write strobe per address
  wire [63:0] wr_at;

  assign wr_at = {63'h0, wr_ok} << cmd_addr_in;

  ////////////////////////////////////////////////////////////////////////
  // Plain read/write registers

  wire [7:0] ch1_duty_low;
  wire [7:0] ch1_duty_high;
  wire [7:0] ch2_duty_low;
  wire [7:0] ch2_duty_high;

  rw_reg8 #(.RESET_VALUE(`RST_CONFIG_B), .WR_MASK(`MASK_CONFIG_B))
    u_config_b (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_CONFIG_B]), .wdata_in(wdata),
    .value_out(config_b_out));
  rw_reg8 #(.RESET_VALUE(`RST_SWITCHING_DIVIDER),
    .WR_MASK(`MASK_SWITCHING_DIVIDER))
    u_switching_divider (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_SWITCHING_DIVIDER]), .wdata_in(wdata),
    .value_out(switching_divider_out));
  rw_reg8 #(.RESET_VALUE(`RST_SLOPE_COMP_CFG),
    .WR_MASK(`MASK_SLOPE_COMP_CFG))
    u_slope_comp_cfg (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_SLOPE_COMP_CFG]), .wdata_in(wdata),
    .value_out(slope_comp_cfg_out));
  rw_reg8 #(.RESET_VALUE(`RST_SPREAD_SPECTRUM_CFG),
    .WR_MASK(`MASK_SPREAD_SPECTRUM_CFG))
    u_spread_spectrum_cfg (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_SPREAD_SPECTRUM_CFG]), .wdata_in(wdata),
    .value_out(spread_spectrum_cfg_out));
  rw_reg8 #(.RESET_VALUE(`RST_RAMP_TIME_CFG), .WR_MASK(`MASK_FULL))
    u_ramp_time_cfg (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_RAMP_TIME_CFG]), .wdata_in(wdata),
    .value_out(ramp_time_cfg_out));
  rw_reg8 #(.RESET_VALUE(`RST_CH1_CURRENT_LEVEL), .WR_MASK(`MASK_FULL))
    u_ch1_current_level (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_CH1_CURRENT_LEVEL]), .wdata_in(wdata),
    .value_out(ch1_current_level_out));
  rw_reg8 #(.RESET_VALUE(`RST_CH2_CURRENT_LEVEL), .WR_MASK(`MASK_FULL))
    u_ch2_current_level (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_CH2_CURRENT_LEVEL]), .wdata_in(wdata),
    .value_out(ch2_current_level_out));
  rw_reg8 #(.RESET_VALUE(`RST_DIMMING_CLOCK_DIVIDER),
    .WR_MASK(`MASK_DIMMING_CLOCK_DIVIDER))
    u_dimming_clock_divider (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_DIMMING_CLOCK_DIVIDER]), .wdata_in(wdata),
    .value_out(dimming_clock_divider_out));
  rw_reg8 #(.RESET_VALUE(`RST_CH1_DIM_DUTY_LOW), .WR_MASK(`MASK_FULL))
    u_ch1_dim_duty_low (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_CH1_DIM_DUTY_LOW]), .wdata_in(wdata),
    .value_out(ch1_duty_low));
  rw_reg8 #(.RESET_VALUE(`RST_CH1_DIM_DUTY_HIGH),
    .WR_MASK(`MASK_DIM_DUTY_HIGH))
    u_ch1_dim_duty_high (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_CH1_DIM_DUTY_HIGH]), .wdata_in(wdata),
    .value_out(ch1_duty_high));
  rw_reg8 #(.RESET_VALUE(`RST_CH2_DIM_DUTY_LOW), .WR_MASK(`MASK_FULL))
    u_ch2_dim_duty_low (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_CH2_DIM_DUTY_LOW]), .wdata_in(wdata),
    .value_out(ch2_duty_low));
  rw_reg8 #(.RESET_VALUE(`RST_CH2_DIM_DUTY_HIGH),
    .WR_MASK(`MASK_DIM_DUTY_HIGH))
    u_ch2_dim_duty_high (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_CH2_DIM_DUTY_HIGH]), .wdata_in(wdata),
    .value_out(ch2_duty_high));
  rw_reg8 #(.RESET_VALUE(`RST_CURRENT_LIMIT_CFG), .WR_MASK(`MASK_FULL))
    u_current_limit_cfg (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_CURRENT_LIMIT_CFG]), .wdata_in(wdata),
    .value_out(current_limit_cfg_out));
  rw_reg8 #(.RESET_VALUE(`RST_CURRENT_FAULT_TIMER),
    .WR_MASK(`MASK_CURRENT_FAULT_TIMER))
    u_current_fault_timer (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_CURRENT_FAULT_TIMER]), .wdata_in(wdata),
    .value_out(current_fault_timer_out));
  rw_reg8 #(.RESET_VALUE(`RST_MODE_FAULT_TIMER), .WR_MASK(`MASK_FULL))
    u_mode_fault_timer (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_MODE_FAULT_TIMER]), .wdata_in(wdata),
    .value_out(mode_fault_timer_out));
  rw_reg8 #(.RESET_VALUE(`RST_FAULT_ENABLE_A), .WR_MASK(`MASK_FULL))
    u_fault_enable_a (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_FAULT_ENABLE_A]), .wdata_in(wdata),
    .value_out(fault_enable_a_out));
  rw_reg8 #(.RESET_VALUE(`RST_FAULT_ENABLE_B),
    .WR_MASK(`MASK_FAULT_ENABLE_B))
    u_fault_enable_b (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_FAULT_ENABLE_B]), .wdata_in(wdata),
    .value_out(fault_enable_b_out));
  rw_reg8 #(.RESET_VALUE(`RST_FAULT_LATCH_SELECT), .WR_MASK(`MASK_FULL))
    u_fault_latch_select (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_FAULT_LATCH_SELECT]), .wdata_in(wdata),
    .value_out(fault_latch_select_out));
  rw_reg8 #(.RESET_VALUE(`RST_OUTPUT_HIGH_LIMIT_SELECT),
    .WR_MASK(`MASK_OUTPUT_HIGH_LIMIT_SELECT))
    u_output_high_limit_select (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_OUTPUT_HIGH_LIMIT_SELECT]), .wdata_in(wdata),
    .value_out(output_high_limit_select_out));
  rw_reg8 #(.RESET_VALUE(`RST_LIMP_HOME_CONFIG), .WR_MASK(`MASK_FULL))
    u_limp_home_config (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_LIMP_HOME_CONFIG]), .wdata_in(wdata),
    .value_out(limp_home_config_out));
  rw_reg8 #(.RESET_VALUE(`RST_LIMP_HOME_CH1_CURRENT), .WR_MASK(`MASK_FULL))
    u_limp_home_ch1_current (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_LIMP_HOME_CH1_CURRENT]), .wdata_in(wdata),
    .value_out(limp_home_ch1_current_out));
  rw_reg8 #(.RESET_VALUE(`RST_LIMP_HOME_CH2_CURRENT), .WR_MASK(`MASK_FULL))
    u_limp_home_ch2_current (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr_in(wr_at[`OFF_LIMP_HOME_CH2_CURRENT]), .wdata_in(wdata),
    .value_out(limp_home_ch2_current_out));

  assign ch1_dim_duty_out = {ch1_duty_high[1:0], ch1_duty_low};
  assign ch2_dim_duty_out = {ch2_duty_high[1:0], ch2_duty_low};

  ////////////////////////////////////////////////////////////////////////
  // Fault status, cleared by an error-free read

  wire clr_fault_a;
  wire clr_fault_b;
  wire [7:0] fault_a_set;

  assign clr_fault_a = rd_ok & ~cmd_error_in &
    (cmd_addr_in == `OFF_FAULT_STATUS_A);
  assign clr_fault_b = rd_ok & ~cmd_error_in &
    (cmd_addr_in == `OFF_FAULT_STATUS_B);
  // Power-cycled flag comes up set out of reset
  assign fault_a_set = fault_a_set_in;

  fault_status_reg #(.RESET_VALUE(`RST_FAULT_STATUS_A),
    .MASK(`MASK_FAULT_STATUS_A))
    u_fault_status_a (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .set_in(fault_a_set), .clear_in(clr_fault_a),
    .value_out(fault_status_a_out));
  fault_status_reg #(.RESET_VALUE(8'h00), .MASK(`MASK_FULL))
    u_fault_status_b (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .set_in(fault_b_set_in), .clear_in(clr_fault_b),
    .value_out(fault_status_b_out));

  wire power_cycled_flag;
  assign power_cycled_flag = fault_status_a_out[`BIT_POWER_CYCLED];

  ////////////////////////////////////////////////////////////////////////
  // Channel-on control and config_a

  reg [7:0] channel_on_q;
  reg [7:0] channel_on_d;
  reg [7:0] config_a_q;
  reg [7:0] config_a_d;

  always @*
  begin
    channel_on_d = channel_on_q;
    if (wr_at[`OFF_CHANNEL_ON_CONTROL])
    begin
      channel_on_d = wdata;
      channel_on_d[`BIT_FAULT_PIN_CLEAR] = 1'b0;
      if (power_cycled_flag)
      begin
        channel_on_d[`BIT_CH1_ON] = wdata[`BIT_CH1_ON] &
          channel_on_q[`BIT_CH1_ON];
        channel_on_d[`BIT_CH2_ON] = wdata[`BIT_CH2_ON] &
          channel_on_q[`BIT_CH2_ON];
      end
    end
    if (ch1_latched_fault_in)
      channel_on_d[`BIT_CH1_ON] = 1'b0;
    if (ch2_latched_fault_in)
      channel_on_d[`BIT_CH2_ON] = 1'b0;
  end

  // Limp-home bit: the pin sets it, only reset or a write of zero clears it
  always @*
  begin
    config_a_d = config_a_q;
    if (wr_at[`OFF_CONFIG_A])
    begin
      config_a_d = wdata;
      config_a_d[`BIT_LIMP_HOME] = config_a_q[`BIT_LIMP_HOME] &
        wdata[`BIT_LIMP_HOME];
    end
    if (limp_home_pin_in)
      config_a_d[`BIT_LIMP_HOME] = 1'b1;
  end

  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      channel_on_q <= `RST_CHANNEL_ON_CONTROL;
      config_a_q <= `RST_CONFIG_A;
      fault_pin_clear_out <= 1'b0;
    end
    else
    begin
      channel_on_q <= channel_on_d;
      config_a_q <= config_a_d;
      fault_pin_clear_out <= wr_at[`OFF_CHANNEL_ON_CONTROL] &
        wdata[`BIT_FAULT_PIN_CLEAR];
    end
  end

  assign channel_on_control_out = channel_on_q;
  assign config_a_out = config_a_q;

  ////////////////////////////////////////////////////////////////////////
  // Read path

  reg [7:0] rmux;

  always @*
  begin
    if (cmd_addr_in == `OFF_CHANNEL_ON_CONTROL)
      rmux = channel_on_q;
    else if (cmd_addr_in == `OFF_CONFIG_A)
      rmux = config_a_q;
    else if (cmd_addr_in == `OFF_CONFIG_B)
      rmux = config_b_out;
    else if (cmd_addr_in == `OFF_SWITCHING_DIVIDER)
      rmux = switching_divider_out;
    else if (cmd_addr_in == `OFF_SLOPE_COMP_CFG)
      rmux = slope_comp_cfg_out;
    else if (cmd_addr_in == `OFF_SPREAD_SPECTRUM_CFG)
      rmux = spread_spectrum_cfg_out;
    else if (cmd_addr_in == `OFF_RAMP_TIME_CFG)
      rmux = ramp_time_cfg_out;
    else if (cmd_addr_in == `OFF_CH1_CURRENT_LEVEL)
      rmux = ch1_current_level_out;
    else if (cmd_addr_in == `OFF_CH2_CURRENT_LEVEL)
      rmux = ch2_current_level_out;
    else if (cmd_addr_in == `OFF_DIMMING_CLOCK_DIVIDER)
      rmux = dimming_clock_divider_out;
    else if (cmd_addr_in == `OFF_CH1_DIM_DUTY_LOW)
      rmux = ch1_duty_low;
    else if (cmd_addr_in == `OFF_CH1_DIM_DUTY_HIGH)
      rmux = ch1_duty_high;
    else if (cmd_addr_in == `OFF_CH2_DIM_DUTY_LOW)
      rmux = ch2_duty_low;
    else if (cmd_addr_in == `OFF_CH2_DIM_DUTY_HIGH)
      rmux = ch2_duty_high;
    else if (cmd_addr_in == `OFF_CURRENT_LIMIT_CFG)
      rmux = current_limit_cfg_out;
    else if (cmd_addr_in == `OFF_CURRENT_FAULT_TIMER)
      rmux = current_fault_timer_out;
    else if (cmd_addr_in == `OFF_MODE_FAULT_TIMER)
      rmux = mode_fault_timer_out;
    else if (cmd_addr_in == `OFF_FAULT_STATUS_A)
      rmux = fault_status_a_out;
    else if (cmd_addr_in == `OFF_FAULT_STATUS_B)
      rmux = fault_status_b_out;
    else if (cmd_addr_in == `OFF_FAULT_ENABLE_A)
      rmux = fault_enable_a_out;
    else if (cmd_addr_in == `OFF_FAULT_ENABLE_B)
      rmux = fault_enable_b_out;
    else if (cmd_addr_in == `OFF_FAULT_LATCH_SELECT)
      rmux = fault_latch_select_out;
    else if (cmd_addr_in == `OFF_OUTPUT_HIGH_LIMIT_SELECT)
      rmux = output_high_limit_select_out;
    else if (cmd_addr_in == `OFF_LIMP_HOME_CONFIG)
      rmux = limp_home_config_out;
    else if (cmd_addr_in == `OFF_LIMP_HOME_CH1_CURRENT)
      rmux = limp_home_ch1_current_out;
    else if (cmd_addr_in == `OFF_LIMP_HOME_CH2_CURRENT)
      rmux = limp_home_ch2_current_out;
    else
      rmux = 8'h00;
  end

  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      rdata_out <= 8'h00;
      rdata_valid_out <= 1'b0;
    end
    else
    begin
      rdata_valid_out <= rd_ok;
      if (rd_ok)
        rdata_out <= rmux;
    end
  end

endmodule

// ### testbench/host_model.sv
// Purpose: Host model issuing decoded command strobes to the bank
// Assumes: Requests change just after a rising edge and hold one cycle
// Notes: Tasks put and idle are called by the bench
`timescale 1ns/1ps
`include "regbank_defines.vh"
module host_model (
  input wire ref_clk_in,
  output reg cmd_valid_out,
  output reg cmd_write_out,
  output reg cmd_error_out,
  output reg [5:0] cmd_addr_out,
  output reg [7:0] cmd_wdata_out
);
  initial
  begin
    cmd_valid_out = 1'b0;
    cmd_write_out = 1'b0;
    cmd_error_out = 1'b0;
    cmd_addr_out = 6'h00;
    cmd_wdata_out = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Present one command, valid low for a write above 0x19; taken at the next rising edge
  task put(input w, input e, input [5:0] a, input [7:0] d);
  begin
    @(posedge ref_clk_in);
    cmd_valid_out <= !(w && (a > `OFF_LAST));
    cmd_write_out <= w;
    cmd_error_out <= e;
    cmd_addr_out <= a;
    cmd_wdata_out <= w ? d : 8'h00;
  end
  endtask

  task idle;
  begin
    @(posedge ref_clk_in);
    cmd_valid_out <= 1'b0;
  end
  endtask
endmodule

// ### testbench/led_regbank_sva.sv
// Purpose: Port-level checker of the register bank
// Assumes: Single clock, synchronous active-high reset
// Notes: Bound to the bank's top module
`timescale 1ns/1ps
`include "regbank_defines.vh"
module led_regbank_sva (
  input wire ref_clk_in,
  input wire rst_in,
  input wire cmd_valid_in,
  input wire cmd_write_in,
  input wire cmd_error_in,
  input wire [5:0] cmd_addr_in,
  input wire [7:0] cmd_wdata_in,
  input wire [7:0] fault_a_set_in,
  input wire [7:0] rdata_out,
  input wire rdata_valid_out,
  input wire fault_pin_clear_out,
  input wire [7:0] channel_on_control_out,
  input wire [7:0] ramp_time_cfg_out,
  input wire [7:0] fault_status_a_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_read;
    cmd_valid_in && !cmd_write_in;
  endsequence
  sequence s_clean_write;
    cmd_valid_in && cmd_write_in && !cmd_error_in;
  endsequence
  sequence s_clear_req;
    s_clean_write ##0 (cmd_addr_in == 6'h00 && cmd_wdata_in[7]);
  endsequence

  ////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (s_read |=> rdata_valid_out)
    else $error("read not answered");
  a_no_spurious: assert property (rdata_valid_out |->
    $past(cmd_valid_in && !cmd_write_in))
    else $error("read data valid without a read");
  a_undef_zero: assert property (s_read ##0 (cmd_addr_in > 6'h19) |=>
    rdata_out == 8'h00)
    else $error("undefined read not zero");
  a_write_lands: assert property (s_clean_write ##0
    (cmd_addr_in == 6'h06) |=> ramp_time_cfg_out == $past(cmd_wdata_in))
    else $error("clean write did not land");
  a_err_hold: assert property (cmd_valid_in && cmd_write_in &&
    cmd_error_in |=> $stable(ramp_time_cfg_out))
    else $error("errored write landed");
  a_read_clears: assert property (s_read ##0 (!cmd_error_in &&
    cmd_addr_in == 6'h11 && fault_a_set_in == 8'h00) |=>
    fault_status_a_out == 8'h00)
    else $error("status read did not clear");
  a_pin_clear_pulse: assert property (s_clear_req |=> fault_pin_clear_out)
    else $error("fault pin clear not pulsed");
  a_pin_clear_cause: assert property (fault_pin_clear_out |->
    $past(cmd_valid_in && cmd_write_in && !cmd_error_in &&
    cmd_wdata_in[7] && cmd_addr_in == 6'h00))
    else $error("fault pin clear without a write");
  a_bit7_zero: assert property (channel_on_control_out[7] == 1'b0)
    else $error("write-only bit visible");
  a_pc_blocks_on: assert property (fault_status_a_out[5] |=>
    (channel_on_control_out[1:0] & ~$past(channel_on_control_out[1:0]))
    == 2'b00)
    else $error("channel turned on while power-cycled");
  a_reset_defaults: assert property (disable iff (1'b0) rst_in |=>
    channel_on_control_out == 8'h3c && fault_status_a_out == 8'h20 &&
    ramp_time_cfg_out == 8'h77)
    else $error("reset values wrong");
endmodule

bind led_controller_register_bank led_regbank_sva u_led_regbank_sva (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
  .cmd_write_in(cmd_write_in), .cmd_error_in(cmd_error_in),
  .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in),
  .fault_a_set_in(fault_a_set_in), .rdata_out(rdata_out),
  .rdata_valid_out(rdata_valid_out),
  .fault_pin_clear_out(fault_pin_clear_out),
  .channel_on_control_out(channel_on_control_out),
  .ramp_time_cfg_out(ramp_time_cfg_out),
  .fault_status_a_out(fault_status_a_out)
);

// ### testbench/led_controller_register_bank_test.sv
// Purpose: Self-checking bench of the register bank
// Assumes: Fixed one-cycle read latency, writes visible next cycle
// Notes: Row table for write/read-back, hand tests after it
`timescale 1ns/1ps
`include "regbank_defines.vh"
module led_controller_register_bank_test;
  // Defaults of 0x19 down to 0x00
  localparam [207:0] RST_VALS = {8'h00, 8'h00, 8'h3c, 8'h22, 8'h00, 8'h0f,
    8'h3c, 8'h00, 8'h20, 8'h99, 8'h0a, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h01, 8'h00, 8'h00, 8'h77, 8'h05, 8'h55, 8'h00, 8'h00, 8'h00, 8'h3c};
  // Rows: address, data (reserved bits zero), read-back
  localparam [287:0] ROWS = {24'h00_83_03, 24'h01_0f_0f, 24'h02_c9_c9,
    24'h03_0f_0f, 24'h04_77_77, 24'h05_3f_3f, 24'h06_12_12, 24'h09_07_07,
    24'h0a_a5_a5, 24'h0b_02_02, 24'h10_5a_5a, 24'h19_c3_c3};
  reg ref_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg [7:0] fault_a_set_in = 8'h00;
  reg [7:0] fault_b_set_in = 8'h00;
  reg limp_home_pin_in = 1'b0;
  reg ch1_latched_fault_in = 1'b0;
  reg ch2_latched_fault_in = 1'b0;
  wire cmd_valid, cmd_write, cmd_error, rdata_valid_out, fault_pin_clear_out;
  wire [5:0] cmd_addr;
  wire [7:0] cmd_wdata, rdata_out, channel_on_control_out, config_a_out;
  wire [7:0] fault_status_a_out, fault_status_b_out, ramp_time_cfg_out;
  wire [9:0] ch1_dim_duty_out;
  integer n_errors = 0;
  integer tests_run = 0;
  integer i;
  reg [7:0] rd;

  always #50 ref_clk_in = ~ref_clk_in;

  host_model u_host (.ref_clk_in(ref_clk_in), .cmd_valid_out(cmd_valid),
    .cmd_write_out(cmd_write), .cmd_error_out(cmd_error),
    .cmd_addr_out(cmd_addr), .cmd_wdata_out(cmd_wdata));

  led_controller_register_bank u_led_controller_register_bank (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid),
    .cmd_write_in(cmd_write), .cmd_error_in(cmd_error),
    .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata),
    .fault_a_set_in(fault_a_set_in), .fault_b_set_in(fault_b_set_in),
    .limp_home_pin_in(limp_home_pin_in),
    .ch1_latched_fault_in(ch1_latched_fault_in),
    .ch2_latched_fault_in(ch2_latched_fault_in),
    .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out),
    .fault_pin_clear_out(fault_pin_clear_out),
    .channel_on_control_out(channel_on_control_out),
    .config_a_out(config_a_out), .config_b_out(), .switching_divider_out(),
    .slope_comp_cfg_out(), .spread_spectrum_cfg_out(),
    .ramp_time_cfg_out(ramp_time_cfg_out), .ch1_current_level_out(),
    .ch2_current_level_out(), .dimming_clock_divider_out(),
    .ch1_dim_duty_out(ch1_dim_duty_out), .ch2_dim_duty_out(),
    .current_limit_cfg_out(), .current_fault_timer_out(),
    .mode_fault_timer_out(), .fault_status_a_out(fault_status_a_out),
    .fault_status_b_out(fault_status_b_out), .fault_enable_a_out(),
    .fault_enable_b_out(), .fault_latch_select_out(),
    .output_high_limit_select_out(), .limp_home_config_out(),
    .limp_home_ch1_current_out(), .limp_home_ch2_current_out());

  ////////////////////////////////////////////////////////////////////////
  task check(input [9:0] seen, input [9:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask

  task wr(input e, input [5:0] a, input [7:0] d);
  begin
    u_host.put(1'b1, e, a, d);
    u_host.idle();
    @(negedge ref_clk_in);
  end
  endtask

  task rd_reg(input [5:0] a, input e, output [7:0] d);
  begin
    u_host.put(1'b0, e, a, 8'h00);
    u_host.idle();
    @(negedge ref_clk_in);
    check({9'h000, rdata_valid_out}, 10'h001);
    d = rdata_out;
  end
  endtask

  task stop_test;
  begin
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(negedge ref_clk_in);
    check({2'b00, fault_status_a_out}, 10'h020);
    wr(1'b0, `OFF_CHANNEL_ON_CONTROL, 8'h03);
    check({2'b00, channel_on_control_out}, 10'h000);
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    for (i = 0; i < 64; i = i + 1)
    begin
      rd_reg(i[5:0], 1'b0, rd);
      check({2'b00, rd}, (i < 26) ? {2'b00, RST_VALS[8*i +: 8]} : 10'h000);
    end
    for (i = 0; i < 12; i = i + 1)
    begin
      wr(1'b0, ROWS[24*i+16 +: 6], ROWS[24*i+8 +: 8]);
      rd_reg(ROWS[24*i+16 +: 6], 1'b0, rd);
      check({2'b00, rd}, {2'b00, ROWS[24*i +: 8]});
    end
    check(ch1_dim_duty_out, 10'h2a5);
    wr(1'b1, `OFF_RAMP_TIME_CFG, 8'h55);
    check({2'b00, ramp_time_cfg_out}, 10'h012);
    // Fault events, then errored and clean status reads
    @(posedge ref_clk_in);
    fault_a_set_in <= 8'h41;
    fault_b_set_in <= 8'h80;
    @(posedge ref_clk_in);
    fault_a_set_in <= 8'h00;
    fault_b_set_in <= 8'h00;
    rd_reg(`OFF_FAULT_STATUS_A, 1'b1, rd);
    check({2'b00, fault_status_a_out}, 10'h001);
    rd_reg(`OFF_FAULT_STATUS_A, 1'b0, rd);
    check({2'b00, rd}, 10'h001);
    check({2'b00, fault_status_a_out}, 10'h000);
    rd_reg(`OFF_FAULT_STATUS_B, 1'b0, rd);
    check({2'b00, rd}, 10'h080);
    check({2'b00, fault_status_b_out}, 10'h000);
    // Latched faults drop channels; limp pin sets its bit
    @(posedge ref_clk_in);
    ch1_latched_fault_in <= 1'b1;
    @(posedge ref_clk_in);
    ch1_latched_fault_in <= 1'b0;
    ch2_latched_fault_in <= 1'b1;
    limp_home_pin_in <= 1'b1;
    @(posedge ref_clk_in);
    ch2_latched_fault_in <= 1'b0;
    limp_home_pin_in <= 1'b0;
    @(negedge ref_clk_in);
    check({2'b00, channel_on_control_out}, 10'h000);
    check({2'b00, config_a_out}, 10'h01f);
    wr(1'b0, `OFF_CHANNEL_ON_CONTROL, 8'h81);
    check({9'h000, fault_pin_clear_out}, 10'h001);
    check({2'b00, channel_on_control_out}, 10'h001);
    wr(1'b0, `OFF_CONFIG_A, 8'h00);
    check({2'b00, config_a_out}, 10'h000);
    stop_test;
  end
endmodule
